/* common/wpr_pkg.sv */
package wpr_pkg;
  // Register addresses on the special register bus
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] AUXILIARY_CONTROL_ADDR = 8'h8e;
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'h8f;

  // Watchdog control field positions
  localparam int WATCHDOG_ENABLE_POS = 7;
  localparam int WATCHDOG_RESTART_POS = 6;
  localparam int WATCHDOG_IDLE_RUN_POS = 5;
  localparam int PRESCALE_SELECT_LSB = 0;
  localparam int PRESCALE_SELECT_BITS = 3;

  // Power control field positions
  localparam int POWER_OFF_FLAG_POS = 4;
  localparam int GENERAL_FLAG_1_POS = 3;
  localparam int GENERAL_FLAG_0_POS = 2;
  localparam int POWER_DOWN_POS = 1;
  localparam int IDLE_POS = 0;

  // Auxiliary control field positions
  localparam int STROBE_SUPPRESS_POS = 0;

  // Values loaded at reset
  localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
  localparam logic [7:0] AUXILIARY_CONTROL_RST = 8'h00;
  localparam logic [7:0] WATCHDOG_CONTROL_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [7:0] STACK_POINTER_RST = 8'h07;
  localparam logic [7:0] OTHER_SFR_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Timing: oscillator halved, six states of two phases per machine cycle
  localparam int OSC_DIVIDE = 2;
  localparam int STATES_PER_MC = 6;
  localparam int MC_OSC_PERIODS = OSC_DIVIDE * STATES_PER_MC;
  localparam int RESET_SAMPLE_STATE = 5;
  localparam int RESET_MIN_MC = 2;
  localparam int WDT_COUNTER_BITS = 14;
  localparam int WDT_PRESCALE_BITS = 8;

  // Power modes
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_POWER_DOWN = 2'b10
  } power_mode_e;
endpackage

/* src/wdt_divider.sv */
`timescale 1ns/1ps
module wdt_divider #(
  parameter int PRESCALE_BITS = wpr_pkg::WDT_PRESCALE_BITS,
  parameter int COUNT_BITS = wpr_pkg::WDT_COUNTER_BITS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic run,
  input wire logic tick,
  input wire logic [2:0] select,
  output logic timeout,
  output logic [COUNT_BITS-1:0] count
);
  // The select decode only spans eight prescaler bits
  if (PRESCALE_BITS != 8) begin : g_bad_prescale
    $error("wdt_divider: prescaler must be 8 bits");
  end
  if (COUNT_BITS < 2) begin : g_bad_count
    $error("wdt_divider: counter needs at least 2 bits");
  end

  logic [7:0] pre_ff; // Free-running prescaler
  logic [COUNT_BITS-1:0] cnt_ff; // Main time-out counter
  logic timeout_ff; // One-cycle time-out pulse
  logic [7:0] mask; // Prescaler bits that must be all ones
  logic pre_done; // Prescaler wraps on this tick

  // Ratio 2^(select+1); code 7 wraps to all ones, giving 256
  assign mask = (8'h02 << select) - 8'h01;
  assign pre_done = tick && ((pre_ff & mask) == mask);

  // Clear beats counting so a restart never lets a stale count through
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 8'h00;
      cnt_ff <= '0;
      timeout_ff <= 1'b0;
    end else if (clear) begin
      pre_ff <= 8'h00;
      cnt_ff <= '0;
      timeout_ff <= 1'b0;
    end else if (run && tick) begin
      pre_ff <= pre_ff + 8'h01;
      timeout_ff <= pre_done && (&cnt_ff);
      if (pre_done) begin
        cnt_ff <= cnt_ff + {{(COUNT_BITS-1){1'b0}}, 1'b1};
      end
    end else begin
      // Held while stopped in idle or power-down
      timeout_ff <= 1'b0;
    end
  end

  assign timeout = timeout_ff;
  assign count = cnt_ff;

  a_count_advance: assert property (@(posedge clock) disable iff (!rst_n)
    (run && pre_done && !clear && !(&cnt_ff)) |=> cnt_ff == $past(cnt_ff) + 1'b1)
    else $error("counter did not advance on prescaler wrap");
  a_prescale_gate: assert property (@(posedge clock) disable iff (!rst_n)
    ($changed(cnt_ff) && !$past(clear)) |-> ($past(pre_ff) & $past(mask)) == $past(mask))
    else $error("counter moved without prescaler wrap");
  a_timeout_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    timeout_ff |-> (cnt_ff == '0) && $past(&cnt_ff))
    else $error("time-out without counter wrap");
  a_clear_zero: assert property (@(posedge clock) disable iff (!rst_n)
    clear |=> (cnt_ff == '0) && (pre_ff == 8'h00) && !timeout_ff)
    else $error("clear left watchdog counts");
endmodule

/* src/watchdog_power_reset_ctrl.sv */
// Behaviour
// - Prescale select picks ratio two to 256
// - Time-out after 2^14 x prescale x 12
// - Enable bit seven starts watchdog counting
// - Enabled time-out generates system reset
// - Restart bit clears counts, self-clears next cycle
// - Idle-run bit lets watchdog count in idle
// - Any reset disables and clears watchdog
// - Oscillator divided by two internally
// - Idle bit stops core; interrupt/reset exits
// - Power-down stops core, peripheral and oscillator clocks; reset exits
// - Power-off flag set at power-on, software clears
// - Two general flags are plain storage
// - Suppress bit stops address latch strobe
// - Strobe still driven during external accesses
// - Reset pin sampled state5 phase2, two cycles
// - Reset glitches are filtered out
// - Reset loads documented default register values
`timescale 1ns/1ps
module watchdog_power_reset_ctrl #(
  parameter int WDT_COUNT_BITS = wpr_pkg::WDT_COUNTER_BITS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic reset_pin,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic interrupt_req,
  input wire logic ext_access,
  input wire logic ale_request,
  output logic ale_out,
  output logic cpu_clock_en,
  output logic periph_clock_en,
  output logic osc_enable,
  output logic core_reset,
  output logic machine_tick,
  output logic idle_mode,
  output logic power_down_mode
);
  // Counter must be long enough for the wrap logic
  if (WDT_COUNT_BITS < 2 || WDT_COUNT_BITS > wpr_pkg::WDT_COUNTER_BITS) begin : g_bad_width
    $error("watchdog_power_reset_ctrl: WDT_COUNT_BITS out of range");
  end

  localparam logic [2:0] LAST_STATE = 3'(wpr_pkg::STATES_PER_MC - 1);
  localparam logic [2:0] SAMPLE_STATE = 3'(wpr_pkg::RESET_SAMPLE_STATE - 1);
  localparam logic [1:0] RST_MIN = 2'(wpr_pkg::RESET_MIN_MC);

  // Local reset release
  logic rst_meta_ff; // First release stage
  logic rst_n_ff; // Released reset used everywhere

  // Reset pin synchroniser and filter
  logic pin_s1_ff; // Metastability stage, read only by the next stage
  logic pin_s2_ff; // Second stage
  logic pin_s3_ff; // Third stage
  logic pin_level_ff; // Accepted pin level
  logic [1:0] rst_cnt_ff; // Consecutive high samples, saturating
  logic ext_reset; // Filtered external reset request

  // Machine cycle sequencer
  logic phase_ff; // Low for phase 1, high for phase 2
  logic [2:0] state_ff; // State 1..6 coded 0..5
  logic sample_strobe; // State 5 phase 2
  logic mc_tick; // Last phase of a machine cycle

  // System reset generation
  logic [1:0] wdt_hold_ff; // Machine cycles of watchdog reset left
  logic sys_reset_ff; // Reset to the core and to our registers

  // Register state
  wpr_pkg::power_mode_e mode_ff; // Run, idle or power-down
  wpr_pkg::power_mode_e nxt_mode; // Next power mode
  logic pof_ff; // Power-off flag
  logic [1:0] gen_flag_ff; // General flags 1 and 0
  logic strobe_suppress_ff; // Strobe suppression
  logic wdt_enable_ff; // Watchdog enable
  logic wdt_restart_ff; // Restart request, self clearing
  logic wdt_idle_run_ff; // Keep counting in idle
  logic [2:0] prescale_sel_ff; // Prescaler select
  logic ale_ff; // Registered strobe output
  logic [7:0] rdata_ff; // Registered read data

  // Decode and datapath
  logic wr_power_control; // Write to power control
  logic wr_aux; // Write to auxiliary control
  logic wr_wdt; // Write to watchdog control
  logic [7:0] rd_value; // Read mux output
  logic rd_hit; // Address is one of ours
  logic wdt_run; // Watchdog allowed to count
  logic wdt_clear; // Clear watchdog counts
  logic wdt_timeout; // Time-out pulse from divider
  logic [WDT_COUNT_BITS-1:0] wdt_count; // Current counter value

  // Reset release: asserted at once, released after two edges
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // Three-stage pin sync; a level counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
      pin_level_ff <= 1'b0;
    end else begin
      pin_s1_ff <= reset_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      if (pin_s2_ff == pin_s3_ff) begin
        pin_level_ff <= pin_s3_ff;
      end
    end
  end

  // Clock halving and state sequence; keeps running in power-down so
  // the reset pin can still wake the part
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      phase_ff <= 1'b0;
      state_ff <= 3'h0;
    end else begin
      phase_ff <= ~phase_ff;
      if (phase_ff) begin
        state_ff <= (state_ff == LAST_STATE) ? 3'h0 : state_ff + 3'h1;
      end
    end
  end

  assign sample_strobe = phase_ff && (state_ff == SAMPLE_STATE);
  assign mc_tick = phase_ff && (state_ff == LAST_STATE);

  // Reset filter: needs two consecutive high samples, one apart per cycle
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rst_cnt_ff <= 2'h0;
    end else if (sample_strobe) begin
      if (!pin_level_ff) begin
        rst_cnt_ff <= 2'h0;
      end else if (rst_cnt_ff != RST_MIN) begin
        rst_cnt_ff <= rst_cnt_ff + 2'h1;
      end
    end
  end

  assign ext_reset = (rst_cnt_ff == RST_MIN);

  // Watchdog reset is stretched so the core sees a full reset
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wdt_hold_ff <= 2'h0;
    end else if (wdt_timeout) begin
      wdt_hold_ff <= RST_MIN;
    end else if (mc_tick && wdt_hold_ff != 2'h0) begin
      wdt_hold_ff <= wdt_hold_ff - 2'h1;
    end
  end

  // Combined system reset; held from power-on until the first edge
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sys_reset_ff <= 1'b1;
    end else begin
      sys_reset_ff <= ext_reset || (wdt_hold_ff != 2'h0);
    end
  end

  // Writes are ignored while the system is held in reset
  assign wr_power_control = sfr_we && !sys_reset_ff && (sfr_addr == wpr_pkg::POWER_CONTROL_ADDR);
  assign wr_aux = sfr_we && !sys_reset_ff && (sfr_addr == wpr_pkg::AUXILIARY_CONTROL_ADDR);
  assign wr_wdt = sfr_we && !sys_reset_ff && (sfr_addr == wpr_pkg::WATCHDOG_CONTROL_ADDR);

  // Next power mode; power-down takes precedence when both bits are written
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      wpr_pkg::MODE_RUN: begin
        if (wr_power_control && sfr_wdata[wpr_pkg::POWER_DOWN_POS]) begin
          nxt_mode = wpr_pkg::MODE_POWER_DOWN;
        end else if (wr_power_control && sfr_wdata[wpr_pkg::IDLE_POS]) begin
          nxt_mode = wpr_pkg::MODE_IDLE;
        end
      end
      wpr_pkg::MODE_IDLE: begin
        // Any pending interrupt wakes the core
        if (interrupt_req) begin
          nxt_mode = wpr_pkg::MODE_RUN;
        end
      end
      wpr_pkg::MODE_POWER_DOWN: begin
        // Only the reset branch below leaves this mode
        nxt_mode = wpr_pkg::MODE_POWER_DOWN;
      end
      default: begin
        // Unused code recovers to run
        nxt_mode = wpr_pkg::MODE_RUN;
      end
    endcase
    if (sys_reset_ff) begin
      nxt_mode = wpr_pkg::MODE_RUN;
    end
  end

  // Power mode register
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mode_ff <= wpr_pkg::MODE_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Power-off flag survives warm resets; a write of zero clears it
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pof_ff <= 1'b1;
    end else if (wr_power_control && !sfr_wdata[wpr_pkg::POWER_OFF_FLAG_POS]) begin
      pof_ff <= 1'b0;
    end
  end

  // General flags: storage only
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      gen_flag_ff <= 2'h0;
    end else if (sys_reset_ff) begin
      gen_flag_ff <= wpr_pkg::POWER_CONTROL_RST[wpr_pkg::GENERAL_FLAG_1_POS -: 2];
    end else if (wr_power_control) begin
      gen_flag_ff <= sfr_wdata[wpr_pkg::GENERAL_FLAG_1_POS -: 2];
    end
  end

  // Auxiliary control
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      strobe_suppress_ff <= 1'b0;
    end else if (sys_reset_ff) begin
      strobe_suppress_ff <= wpr_pkg::AUXILIARY_CONTROL_RST[wpr_pkg::STROBE_SUPPRESS_POS];
    end else if (wr_aux) begin
      strobe_suppress_ff <= sfr_wdata[wpr_pkg::STROBE_SUPPRESS_POS];
    end
  end

  // Watchdog control fields; reset disables the watchdog
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wdt_enable_ff <= 1'b0;
      wdt_idle_run_ff <= 1'b0;
      prescale_sel_ff <= 3'h0;
    end else if (sys_reset_ff) begin
      wdt_enable_ff <= wpr_pkg::WATCHDOG_CONTROL_RST[wpr_pkg::WATCHDOG_ENABLE_POS];
      wdt_idle_run_ff <= wpr_pkg::WATCHDOG_CONTROL_RST[wpr_pkg::WATCHDOG_IDLE_RUN_POS];
      prescale_sel_ff <= wpr_pkg::WATCHDOG_CONTROL_RST[2:0];
    end else if (wr_wdt) begin
      wdt_enable_ff <= sfr_wdata[wpr_pkg::WATCHDOG_ENABLE_POS];
      wdt_idle_run_ff <= sfr_wdata[wpr_pkg::WATCHDOG_IDLE_RUN_POS];
      prescale_sel_ff <= sfr_wdata[wpr_pkg::PRESCALE_SELECT_LSB +: 3];
    end
  end

  // Restart request: a new write wins over the self-clear in the same cycle
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wdt_restart_ff <= 1'b0;
    end else if (sys_reset_ff) begin
      wdt_restart_ff <= 1'b0;
    end else if (wr_wdt && sfr_wdata[wpr_pkg::WATCHDOG_RESTART_POS]) begin
      wdt_restart_ff <= 1'b1;
    end else if (mc_tick) begin
      wdt_restart_ff <= 1'b0;
    end
  end

  // Counting gate: frozen in power-down, in idle only when allowed
  assign wdt_run = wdt_enable_ff && !sys_reset_ff
    && (mode_ff != wpr_pkg::MODE_POWER_DOWN)
    && ((mode_ff != wpr_pkg::MODE_IDLE) || wdt_idle_run_ff);
  assign wdt_clear = sys_reset_ff || (wdt_restart_ff && mc_tick);

  // One tick per twelve oscillator periods feeds the prescaler
  wdt_divider #(
    .PRESCALE_BITS(wpr_pkg::WDT_PRESCALE_BITS),
    .COUNT_BITS(WDT_COUNT_BITS)
  ) u_divider (
    .clock(clock),
    .rst_n(rst_n_ff),
    .clear(wdt_clear),
    .run(wdt_run),
    .tick(mc_tick),
    .select(prescale_sel_ff),
    .timeout(wdt_timeout),
    .count(wdt_count)
  );

  // Strobe passes when not suppressed or during an external access
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ale_ff <= 1'b0;
    end else begin
      ale_ff <= ale_request && (!strobe_suppress_ff || ext_access);
    end
  end

  // Read mux; unused bits read zero
  always_comb begin
    rd_value = wpr_pkg::UNMAPPED_READ;
    rd_hit = 1'b1;
    unique case (sfr_addr)
      wpr_pkg::POWER_CONTROL_ADDR: begin
        rd_value[wpr_pkg::POWER_OFF_FLAG_POS] = pof_ff;
        rd_value[wpr_pkg::GENERAL_FLAG_1_POS -: 2] = gen_flag_ff;
        rd_value[wpr_pkg::POWER_DOWN_POS] = (mode_ff == wpr_pkg::MODE_POWER_DOWN);
        rd_value[wpr_pkg::IDLE_POS] = (mode_ff == wpr_pkg::MODE_IDLE);
      end
      wpr_pkg::AUXILIARY_CONTROL_ADDR: begin
        rd_value[wpr_pkg::STROBE_SUPPRESS_POS] = strobe_suppress_ff;
      end
      wpr_pkg::WATCHDOG_CONTROL_ADDR: begin
        rd_value[wpr_pkg::WATCHDOG_ENABLE_POS] = wdt_enable_ff;
        rd_value[wpr_pkg::WATCHDOG_RESTART_POS] = wdt_restart_ff;
        rd_value[wpr_pkg::WATCHDOG_IDLE_RUN_POS] = wdt_idle_run_ff;
        rd_value[wpr_pkg::PRESCALE_SELECT_LSB +: 3] = prescale_sel_ff;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data registered, held between reads
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff <= 8'h00;
    end else if (sfr_re) begin
      rdata_ff <= rd_value;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign sfr_hit = rd_hit;
  assign ale_out = ale_ff;
  assign core_reset = sys_reset_ff;
  assign machine_tick = mc_tick;
  assign idle_mode = (mode_ff == wpr_pkg::MODE_IDLE);
  assign power_down_mode = (mode_ff == wpr_pkg::MODE_POWER_DOWN);
  assign cpu_clock_en = (mode_ff == wpr_pkg::MODE_RUN);
  assign periph_clock_en = (mode_ff != wpr_pkg::MODE_POWER_DOWN);
  assign osc_enable = (mode_ff != wpr_pkg::MODE_POWER_DOWN);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_ff);

  // Machine cycle: tick, eleven quiet edges, tick again
  sequence s_quiet_cycle;
    (!mc_tick) [*8] ##1 (!mc_tick) [*3];
  endsequence
  sequence s_held_release;
    sys_reset_ff ##1 !sys_reset_ff;
  endsequence

  // Phase sits still on the edge just after release, so that one is skipped
  a_phase_toggle: assert property ($past(rst_n_ff) |-> phase_ff != $past(phase_ff))
    else $error("internal phase did not toggle");
  a_machine_cycle: assert property (mc_tick |=> s_quiet_cycle ##1 mc_tick)
    else $error("machine cycle is not twelve clocks");
  a_restart_clear: assert property ($rose(wdt_restart_ff) |-> ##[1:12] !wdt_restart_ff)
    else $error("restart bit did not self-clear");
  a_idle_gate: assert property ((idle_mode && !wdt_idle_run_ff) |-> !wdt_run)
    else $error("watchdog ran in idle without permission");
  // A reset or a pending restart may still zero the count while powered down
  a_pd_freeze: assert property ((power_down_mode && !wdt_clear) |=> $stable(wdt_count))
    else $error("watchdog moved in power-down");
  a_timeout_reset: assert property (wdt_timeout |-> ##2 sys_reset_ff [*2])
    else $error("time-out did not reset the system");
  a_reset_disable: assert property (s_held_release |-> !wdt_enable_ff && wdt_count == '0)
    else $error("reset left watchdog running");
  a_pof_kept: assert property (sys_reset_ff |=> pof_ff == $past(pof_ff))
    else $error("power-off flag changed during reset");
  a_glitch_ignored: assert property ((sample_strobe && !pin_level_ff) |=> !ext_reset)
    else $error("low sample failed to drop reset");
  a_idle_exit: assert property ((idle_mode && interrupt_req) |=> !idle_mode)
    else $error("interrupt did not end idle");
  a_pd_stays: assert property ((power_down_mode && !sys_reset_ff) |=> power_down_mode)
    else $error("power-down left without reset");
  a_strobe_off: assert property ((strobe_suppress_ff && !ext_access) |=> !ale_out)
    else $error("strobe toggled while suppressed");
  a_strobe_ext: assert property ((ext_access && ale_request) |=> ale_out)
    else $error("strobe missing during external access");
endmodule

/* test/core_bus_model.sv */
`timescale 1ns/1ps
// Core side of the register bus: one byte per strobe, one strobe per call
module core_bus_model (
  input wire logic clock,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic sfr_we,
  output logic sfr_re,
  input wire logic [7:0] sfr_rdata
);
  // Bus idle from time zero
  initial begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_we = 1'b0;
    sfr_re = 1'b0;
  end
  // Write taken at the edge after the strobe rises; stale data scrambled after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_we <= 1'b1;
    @(posedge clock);
    sfr_we <= 1'b0;
    sfr_wdata <= ~d;
  endtask
  // Read data lands on the strobe's edge, so it is taken just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_re <= 1'b1;
    @(posedge clock);
    sfr_re <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask
endmodule

/* test/watchdog_power_reset_ctrl_tb.sv */
`timescale 1ns/1ps
module watchdog_power_reset_ctrl_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic reset_pin = 1'b0;
  logic interrupt_req = 1'b0;
  logic ext_access = 1'b0;
  logic ale_request = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic sfr_we, sfr_re, sfr_hit, ale_out, cpu_clock_en, periph_clock_en, osc_enable;
  logic core_reset, machine_tick, idle_mode, power_down_mode;
  int n_mismatch = 0;
  int samples_checked = 0;
  // 125 MHz oscillator
  always #4 clock = ~clock;
  // Short counter so every prescale code fits the run
  localparam int CNT_BITS = 2;
  // Time-out at ratio two; later codes shift it left
  localparam int TO_CLKS = (1 << CNT_BITS) * 2 * wpr_pkg::MC_OSC_PERIODS;
  // Restart lands on the next machine cycle, plus reset latency
  localparam int SLACK = 2 * wpr_pkg::MC_OSC_PERIODS;
  // Two-bit counter: time-out is 4 x ratio x 12 clocks, all ratios fit the run
  watchdog_power_reset_ctrl #(.WDT_COUNT_BITS(CNT_BITS)) dut (
    .clock(clock), .rstn(rstn), .reset_pin(reset_pin), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .interrupt_req(interrupt_req), .ext_access(ext_access),
    .ale_request(ale_request), .ale_out(ale_out), .cpu_clock_en(cpu_clock_en),
    .periph_clock_en(periph_clock_en), .osc_enable(osc_enable), .core_reset(core_reset),
    .machine_tick(machine_tick), .idle_mode(idle_mode), .power_down_mode(power_down_mode)
  );
  // Core stand-in driving the register bus
  core_bus_model bus (
    .clock(clock), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
    .sfr_re(sfr_re), .sfr_rdata(sfr_rdata)
  );
  // Verdict and end of run
  task automatic final_report();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Counted compare; four-state so unknowns fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Clocks until core_reset shows v, capped so a hang cannot stall the run
  task automatic wait_lvl(input logic v, input int lim, output int n);
    n = 0;
    while (core_reset !== v && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  // Register read with compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bus.rd(a, d);
    chk(d, e);
  endtask
  // Values after power-on, unmapped place reads zero
  task automatic t_reset();
    rchk(8'h87, 8'h10);
    chk(sfr_hit, 1'b1);
    rchk(8'h8e, 8'h00);
    rchk(8'h8f, 8'h00);
    rchk(8'h80, 8'h00);
    chk(sfr_hit, 1'b0);
  endtask
  // Machine cycle is twelve oscillator clocks, six states of the halved oscillator
  task automatic t_tick();
    int n;
    n = 0;
    while (machine_tick !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (machine_tick !== 1'b1 && n < 20);
    chk(n, wpr_pkg::MC_OSC_PERIODS);
  endtask
  // Flags are plain storage; power-off flag only clears
  task automatic t_flags();
    bus.wr(8'h87, 8'h0c);
    rchk(8'h87, 8'h0c);
    bus.wr(8'h87, 8'h10);
    rchk(8'h87, 8'h00);
  endtask
  // Strobe suppressed unless an external access is under way
  task automatic t_strobe(input logic sup, input logic ext, input logic e);
    bus.wr(8'h8e, {7'h00, sup});
    ale_request <= 1'b1;
    ext_access <= ext;
    repeat (2) @(posedge clock);
    #1;
    chk(ale_out, e);
    // Strobe request dropped: output must follow it low
    @(posedge clock);
    ale_request <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(ale_out, 1'b0);
  endtask
  // Restart bit self-clears; timely restarts hold the reset off
  task automatic t_restart();
    int n;
    bus.wr(8'h8f, 8'h47);
    repeat (24) @(posedge clock);
    rchk(8'h8f, 8'h07);
    wait_lvl(1'b1, 300, n);
    chk(n, 300);
    bus.wr(8'h8f, 8'hc0);
    repeat (6) begin
      wait_lvl(1'b1, 50, n);
      chk(n, 50);
      bus.wr(8'h8f, 8'hc0);
    end
    wait_lvl(1'b1, 130, n);
    chk(n >= TO_CLKS && n <= TO_CLKS + SLACK, 1'b1);
    wait_lvl(1'b0, 100, n);
  endtask
  // Every prescale code; the reset that follows disables the watchdog
  task automatic t_prescale();
    int n;
    for (int s = 0; s < 8; s++) begin
      bus.wr(8'h8f, 8'hc0 | 8'(s));
      wait_lvl(1'b1, 13000, n);
      chk(n >= (TO_CLKS << s) && n <= (TO_CLKS << s) + SLACK, 1'b1);
      wait_lvl(1'b0, 100, n);
      rchk(8'h8f, 8'h00);
    end
    rchk(8'h87, 8'h00);
  endtask
  // Idle gates the core; watchdog runs in idle only with the idle-run bit
  task automatic t_idle();
    int n;
    bus.wr(8'h8f, 8'hc0);
    bus.wr(8'h87, 8'h01);
    wait_lvl(1'b1, 300, n);
    chk(n, 300);
    chk({idle_mode, cpu_clock_en, periph_clock_en}, 3'b101);
    // Interrupt raised on a rising edge
    @(posedge clock);
    interrupt_req <= 1'b1;
    repeat (3) @(posedge clock);
    interrupt_req <= 1'b0;
    #1;
    chk(idle_mode, 1'b0);
    wait_lvl(1'b1, 200, n);
    wait_lvl(1'b0, 100, n);
    bus.wr(8'h8f, 8'he0);
    bus.wr(8'h87, 8'h01);
    wait_lvl(1'b1, 200, n);
    chk(n < 200, 1'b1);
    wait_lvl(1'b0, 100, n);
    chk(idle_mode, 1'b0);
  endtask
  // Reset pin held for w clocks; short pulses must be ignored
  task automatic t_pin(input int w, input logic e);
    int n;
    @(posedge clock);
    reset_pin <= 1'b1;
    repeat (w) @(posedge clock);
    reset_pin <= 1'b0;
    wait_lvl(1'b1, 40, n);
    chk(n < 40, e);
    wait_lvl(1'b0, 60, n);
    chk(core_reset, 1'b0);
  endtask
  // Power-down freezes all, ignores interrupts, leaves only by reset
  task automatic t_pdown();
    int n;
    bus.wr(8'h8f, 8'he0);
    bus.wr(8'h87, 8'h02);
    wait_lvl(1'b1, 300, n);
    chk(n, 300);
    chk({power_down_mode, cpu_clock_en, periph_clock_en, osc_enable}, 4'h8);
    // Interrupt raised on a rising edge
    @(posedge clock);
    interrupt_req <= 1'b1;
    repeat (3) @(posedge clock);
    interrupt_req <= 1'b0;
    #1;
    chk(power_down_mode, 1'b1);
    t_pin(40, 1'b1);
    chk({power_down_mode, osc_enable}, 2'b01);
    rchk(8'h8f, 8'h00);
  endtask
  // Power-on reset for ten clocks, then the scenarios in turn
  initial begin
    int n;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    wait_lvl(1'b0, 100, n);
    t_reset();
    t_tick();
    t_flags();
    t_strobe(1'b0, 1'b0, 1'b1);
    t_strobe(1'b1, 1'b0, 1'b0);
    t_strobe(1'b1, 1'b1, 1'b1);
    t_strobe(1'b1, 1'b0, 1'b0);
    t_restart();
    t_prescale();
    t_idle();
    t_pdown();
    t_pin(5, 1'b0);
    final_report();
  end
  // Hang guard, well beyond the roughly 30k clocks the scenarios need
  initial begin
    #600000;
    n_mismatch++;
    final_report();
  end
endmodule
